// *** src/bdrf_pkg.sv ***
//------------------------------------------------------------
// descriptor ring constants
//------------------------------------------------------------
// Operation
// - device takes low buffer address, never alters
// - host keeps receive buffers word aligned
// - host writes even two's complement length
// - host should give management buffers over 14 bytes; host end still posts shorter receive buffers and pulses post_short_len
// - device writes message length when frame ends
// - frame-end flag zero means whole buffer used
// - bit 15 owner flag, handed back and forth
// - no field changes after handing descriptor over
// - bit 14 marks final descriptor of ring
// - bit 13 copied to command/response bit
// - host sets bit 12 on last buffer
// - bits 11..09 copied to congestion and discard bits
// - congestion discards discard-eligible frames unsent
// - bit 08 suppresses transmit interrupt on return
// - device takes high address bits 07:00
// - receive owner cleared only after valid frame
package bdrf_pkg;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 16;
    localparam int IDX_W     = 6;
    localparam int MEM_WORDS = 256;

    // descriptor word 0 field positions
    localparam int OWN_BIT   = 15;
    localparam int EOR_BIT   = 14;
    localparam int CR_BIT    = 13;
    localparam int ELF_BIT   = 12;
    localparam int FECN_BIT  = 11;
    localparam int BECN_BIT  = 10;
    localparam int DE_BIT    = 9;
    localparam int TX_IRQ_SUPPRESS_BIT = 8;
    localparam int HI_MSB    = 7;

    // word offsets inside one four-word entry
    localparam logic [ADDR_W-1:0] WORD0 = 8'h00;
    localparam logic [ADDR_W-1:0] WORD1 = 8'h01;
    localparam logic [ADDR_W-1:0] WORD2 = 8'h02;
    localparam logic [ADDR_W-1:0] WORD3 = 8'h03;

    // controller register offsets
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_TX_BASE = 4'h1;
    localparam logic [3:0] REG_RX_BASE = 4'h2;
    localparam logic [3:0] REG_STATUS  = 4'h3;
    localparam logic [3:0] REG_MASK    = 4'h4;
    localparam logic [3:0] REG_INDEX   = 4'h5;

    // status and mask bits
    localparam int ST_TX   = 0;
    localparam int ST_RX   = 1;
    localparam int ST_DISC = 2;
    localparam int ST_W    = 3;

    localparam logic [DATA_W-1:0] RST_WORD   = 16'h0000;
    localparam logic [ADDR_W-1:0] RST_BASE   = 8'h00;
    localparam logic [IDX_W-1:0]  RST_IDX    = 6'h00;
    localparam logic [ST_W-1:0]   RST_STAT   = 3'h0;
    localparam logic [DATA_W-1:0] LMI_MIN_LEN = 16'h000e;
endpackage : bdrf_pkg

// *** src/bdrf_if.sv ***
`timescale 1ns/1ps
// descriptor memory access: request level held until one-cycle ack
interface bdrf_if;
    logic                      req;
    logic                      we;
    logic [bdrf_pkg::ADDR_W-1:0] addr;
    logic [bdrf_pkg::DATA_W-1:0] wdata;
    logic                      ack;
    logic [bdrf_pkg::DATA_W-1:0] rdata;

    modport dev  (output req, we, addr, wdata, input ack, rdata);
    modport host (input req, we, addr, wdata, output ack, rdata);
endinterface : bdrf_if

// *** src/bdrf_host_end.sv ***
`timescale 1ns/1ps
module bdrf_host_end import bdrf_pkg::*; (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    bdrf_if.host                   dma,
    input  wire logic [ADDR_W-1:0] tx_ring_base,
    input  wire logic [ADDR_W-1:0] rx_ring_base,
    input  wire logic              post_tx,
    input  wire logic              post_rx,
    input  wire logic [IDX_W-1:0]  post_idx,
    input  wire logic [23:0]       post_addr,
    input  wire logic [15:0]       post_len,
    input  wire logic              post_eor,
    input  wire logic              post_more,
    input  wire logic              post_cr,
    input  wire logic              post_fecn,
    input  wire logic              post_becn,
    input  wire logic              post_de,
    input  wire logic              post_tx_irq_suppress,
    output logic                   post_busy,
    output logic                   post_refused,
    output logic                   post_short_len,
    input  wire logic              mem_rd,
    input  wire logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0]      mem_rdata
);
    typedef enum logic [5:0] {
        H_IDLE = 6'b000001,
        H_CHK  = 6'b000010,
        H_W1   = 6'b000100,
        H_W2   = 6'b001000,
        H_W3   = 6'b010000,
        H_W0   = 6'b100000
    } bdrf_hstate_e;

    logic [DATA_W-1:0] mem [MEM_WORDS];
    bdrf_hstate_e      state_ff;
    bdrf_hstate_e      nxt_state;
    logic              is_tx_ff;
    logic [ADDR_W-1:0] entry_ff;
    logic [23:0]       addr_ff;
    logic [15:0]       len_ff;
    logic [7:0]        flags_ff;
    logic              ack_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              refused_ff;
    logic              short_ff;
    logic [DATA_W-1:0] mem_rdata_ff;

    //------------------------------------------------------------
    // command decode
    //------------------------------------------------------------
    wire               idle      = (state_ff == H_IDLE);
    wire               start     = idle && (post_tx || post_rx);
    wire [ADDR_W-1:0]  base_sel  = post_tx ? tx_ring_base : rx_ring_base;
    wire [ADDR_W-1:0]  entry_new = ADDR_W'(base_sel + {post_idx, 2'b00});
    wire [15:0]        len_even  = {post_len[15:1], 1'b0};
    wire [15:0]        len_twos  = 16'(~len_ff + 16'h0001);
    wire               owned     = mem[entry_ff][OWN_BIT];
    wire               serve     = idle && dma.req && !ack_ff;
    // flags_ff: eor, cr, last, fecn, becn, de, tx_irq_suppress, spare
    wire               last_buf  = flags_ff[5];
    wire [DATA_W-1:0]  w0_tx     = {1'b1, flags_ff[7:6], last_buf, flags_ff[4:1],
                                    addr_ff[23:16]};
    wire [DATA_W-1:0]  w0_rx     = {1'b1, flags_ff[7], 6'h00, addr_ff[23:16]};
    wire [DATA_W-1:0]  w1_word   = {addr_ff[15:1], 1'b0};

    //------------------------------------------------------------
    // posting sequence: words 1..3 first, owner word last
    //------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            H_IDLE:  if (start) nxt_state = H_CHK;
            H_CHK:   nxt_state = owned ? H_IDLE : H_W1;
            H_W1:    nxt_state = H_W2;
            H_W2:    nxt_state = H_W3;
            H_W3:    nxt_state = H_W0;
            H_W0:    nxt_state = H_IDLE;
            default: nxt_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= H_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (start) begin
            is_tx_ff <= post_tx;
            entry_ff <= entry_new;
            addr_ff  <= post_addr;
            len_ff   <= len_even;
            flags_ff <= {post_eor, post_cr, !post_more, post_fecn, post_becn, post_de,
                         post_tx_irq_suppress, 1'b0};
        end
    end

    //------------------------------------------------------------
    // descriptor memory, one write per cycle
    //------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem <= '{default: RST_WORD};
        end else if (serve && dma.we) begin
            mem[dma.addr] <= dma.wdata;
        end else if (state_ff == H_W1) begin
            mem[ADDR_W'(entry_ff + WORD1)] <= w1_word;
        end else if (state_ff == H_W2) begin
            mem[ADDR_W'(entry_ff + WORD2)] <= len_twos;
        end else if (state_ff == H_W3) begin
            mem[ADDR_W'(entry_ff + WORD3)] <= is_tx_ff ? len_twos : RST_WORD;
        end else if (state_ff == H_W0) begin
            mem[entry_ff] <= is_tx_ff ? w0_tx : w0_rx;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_ff       <= 1'b0;
            rdata_ff     <= RST_WORD;
            refused_ff   <= 1'b0;
            short_ff     <= 1'b0;
            mem_rdata_ff <= RST_WORD;
        end else begin
            ack_ff       <= serve;
            rdata_ff     <= serve ? mem[dma.addr] : RST_WORD;
            refused_ff   <= (state_ff == H_CHK) && owned;
            short_ff     <= start && !post_tx && (len_even <= LMI_MIN_LEN);
            mem_rdata_ff <= mem_rd ? mem[mem_addr] : RST_WORD;
        end
    end

    assign dma.ack        = ack_ff;
    assign dma.rdata      = rdata_ff;
    assign post_busy      = !state_ff[0];
    assign post_refused   = refused_ff;
    assign post_short_len = short_ff;
    assign mem_rdata      = mem_rdata_ff;
endmodule : bdrf_host_end

// *** src/bdrf_dev_end.sv ***
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module bdrf_dev_end import bdrf_pkg::*; (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    bdrf_if.dev                    dma,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    output logic                   irq,
    output logic                   tx_start,
    output logic [23:0]            tx_buf_addr,
    output logic                   tx_cr,
    output logic                   tx_fecn,
    output logic                   tx_becn,
    output logic                   tx_de,
    output logic                   tx_last,
    input  wire logic              tx_done,
    input  wire logic              tx_congested_flag,
    input  wire logic              rx_frame_end,
    input  wire logic              rx_frame_ok,
    input  wire logic              rx_frame_elf,
    input  wire logic [15:0]       rx_frame_len,
    input  wire logic [3:0]        rx_frame_bits,
    output logic                   rx_ready,
    output logic [23:0]            rx_buf_addr,
    output logic [15:0]            rx_buf_len
);
    typedef enum logic [10:0] {
        S_IDLE = 11'b000_0000_0001,
        S_RX0  = 11'b000_0000_0010,
        S_RX1  = 11'b000_0000_0100,
        S_RX2  = 11'b000_0000_1000,
        S_RX3W = 11'b000_0001_0000,
        S_RX0W = 11'b000_0010_0000,
        S_TX0  = 11'b000_0100_0000,
        S_TX1  = 11'b000_1000_0000,
        S_TXS  = 11'b001_0000_0000,
        S_TXW  = 11'b010_0000_0000,
        S_SPR  = 11'b100_0000_0000
    } bdrf_dstate_e;

    bdrf_dstate_e      state_ff;
    bdrf_dstate_e      nxt_state;
    logic              enable_ff;
    logic [ADDR_W-1:0] tx_base_ff;
    logic [ADDR_W-1:0] rx_base_ff;
    logic [IDX_W-1:0]  tx_idx_ff;
    logic [IDX_W-1:0]  rx_idx_ff;
    logic [ST_W-1:0]   status_ff;
    logic [ST_W-1:0]   mask_ff;
    logic [15:0]       reg_rdata_ff;
    logic              irq_ff;
    logic              turn_ff;
    logic              req_ff;
    logic              we_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] tx_w0_ff;
    logic              tx_start_ff;
    logic [23:0]       tx_addr_ff;
    logic [4:0]        tx_bits_ff;
    logic              rx_have_ff;
    logic              rx_eor_ff;
    logic [7:0]        rx_hi_ff;
    logic [23:0]       rx_addr_ff;
    logic [15:0]       rx_len_ff;
    logic              rx_pend_ff;
    logic              rx_ok_ff;
    logic              rx_elf_ff;
    logic [15:0]       rx_mlen_ff;
    logic [3:0]        rx_bits_ff;

    //------------------------------------------------------------
    // register port decode
    //------------------------------------------------------------
    wire              wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
    wire              wr_txb    = reg_wr && (reg_addr == REG_TX_BASE);
    wire              wr_rxb    = reg_wr && (reg_addr == REG_RX_BASE);
    wire              wr_stat   = reg_wr && (reg_addr == REG_STATUS);
    wire              wr_mask   = reg_wr && (reg_addr == REG_MASK);
    wire [15:0]       rd_mux    =
        (reg_addr == REG_CTRL)    ? {15'h0000, enable_ff} :
        (reg_addr == REG_TX_BASE) ? {8'h00, tx_base_ff} :
        (reg_addr == REG_RX_BASE) ? {8'h00, rx_base_ff} :
        (reg_addr == REG_STATUS)  ? {13'h0000, status_ff} :
        (reg_addr == REG_MASK)    ? {13'h0000, mask_ff} :
        (reg_addr == REG_INDEX)   ? {2'b00, rx_idx_ff, 2'b00, tx_idx_ff} : 16'h0000;

    //------------------------------------------------------------
    // sequencing conditions
    //------------------------------------------------------------
    wire              ack       = dma.ack;
    wire [DATA_W-1:0] rd        = dma.rdata;
    wire              idle      = (state_ff == S_IDLE);
    wire              rx_take   = idle && enable_ff && rx_have_ff && rx_pend_ff;
    wire              rx_drop   = rx_take && !rx_ok_ff;
    wire              dispatch  = idle && enable_ff && !rx_take;
    wire              tx0_ack   = (state_ff == S_TX0) && ack;
    wire              tx1_ack   = (state_ff == S_TX1) && ack;
    wire              txw_ack   = (state_ff == S_TXW) && ack;
    wire              rx0_ack   = (state_ff == S_RX0) && ack && rd[OWN_BIT];
    wire              rx1_ack   = (state_ff == S_RX1) && ack;
    wire              rx2_ack   = (state_ff == S_RX2) && ack;
    wire              rx0w_ack  = (state_ff == S_RX0W) && ack;
    wire              discard   = tx_congested_flag && tx_w0_ff[DE_BIT];
    wire [ADDR_W-1:0] tx_entry  = ADDR_W'(tx_base_ff + {tx_idx_ff, 2'b00});
    wire [ADDR_W-1:0] rx_entry  = ADDR_W'(rx_base_ff + {rx_idx_ff, 2'b00});
    wire [IDX_W-1:0]  tx_next   = tx_w0_ff[EOR_BIT] ? RST_IDX : IDX_W'(tx_idx_ff + 1'b1);
    wire [IDX_W-1:0]  rx_next   = rx_eor_ff ? RST_IDX : IDX_W'(rx_idx_ff + 1'b1);
    wire [DATA_W-1:0] rx_message_length_twos   = 16'(~rx_mlen_ff + 16'h0001);
    wire [DATA_W-1:0] rx_wb     = {1'b0, rx_eor_ff, rx_bits_ff[3], rx_elf_ff,
                                   rx_bits_ff[2:0], 1'b0, rx_hi_ff};
    wire [DATA_W-1:0] tx_wb     = tx_w0_ff & ~(16'h0001 << OWN_BIT);
    wire [ST_W-1:0]   events    = {tx1_ack && discard, rx0w_ack,
                                   txw_ack && !tx_w0_ff[TX_IRQ_SUPPRESS_BIT]};

    //------------------------------------------------------------
    // descriptor walk
    //------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (rx_take) begin
                    nxt_state = !rx_ok_ff ? S_IDLE : (rx_elf_ff ? S_RX3W : S_RX0W);
                end else if (dispatch && !rx_have_ff && !turn_ff) begin
                    nxt_state = S_RX0;
                end else if (dispatch) begin
                    nxt_state = S_TX0;
                end
            end
            S_RX0:   if (ack) nxt_state = rd[OWN_BIT] ? S_RX1 : S_IDLE;
            S_RX1:   if (ack) nxt_state = S_RX2;
            S_RX2:   if (ack) nxt_state = S_IDLE;
            S_RX3W:  if (ack) nxt_state = S_RX0W;
            S_RX0W:  if (ack) nxt_state = S_IDLE;
            S_TX0:   if (ack) nxt_state = rd[OWN_BIT] ? S_TX1 : S_IDLE;
            S_TX1:   if (ack) nxt_state = discard ? S_TXW : S_TXS;
            S_TXS:   if (tx_done) nxt_state = S_TXW;
            S_TXW:   if (ack) nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    wire              nxt_we    = (nxt_state == S_RX3W) || (nxt_state == S_RX0W) ||
                                  (nxt_state == S_TXW);
    wire              nxt_req   = nxt_we || (nxt_state == S_RX0) || (nxt_state == S_RX1) ||
                                  (nxt_state == S_RX2) || (nxt_state == S_TX0) ||
                                  (nxt_state == S_TX1);
    wire [ADDR_W-1:0] nxt_addr  =
        (nxt_state == S_RX1)  ? ADDR_W'(rx_entry + WORD1) :
        (nxt_state == S_RX2)  ? ADDR_W'(rx_entry + WORD2) :
        (nxt_state == S_RX3W) ? ADDR_W'(rx_entry + WORD3) :
        (nxt_state == S_TX0)  ? tx_entry :
        (nxt_state == S_TX1)  ? ADDR_W'(tx_entry + WORD1) :
        (nxt_state == S_TXW)  ? tx_entry : rx_entry;
    wire [DATA_W-1:0] nxt_wdata =
        (nxt_state == S_RX3W) ? rx_message_length_twos :
        (nxt_state == S_RX0W) ? rx_wb :
        (nxt_state == S_TXW)  ? tx_wb : RST_WORD;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= S_IDLE;
            req_ff   <= 1'b0;
            we_ff    <= 1'b0;
            addr_ff  <= RST_BASE;
            wdata_ff <= RST_WORD;
            turn_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            req_ff   <= nxt_req;
            we_ff    <= nxt_we;
            addr_ff  <= nxt_addr;
            wdata_ff <= nxt_wdata;
            turn_ff  <= turn_ff ^ dispatch;
        end
    end

    //------------------------------------------------------------
    // transmit side
    //------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_w0_ff    <= RST_WORD;
            tx_idx_ff   <= RST_IDX;
            tx_start_ff <= 1'b0;
            tx_addr_ff  <= 24'h00_0000;
            tx_bits_ff  <= 5'h00;
        end else begin
            tx_start_ff <= tx1_ack && !discard;
            if (tx0_ack && rd[OWN_BIT]) tx_w0_ff <= rd;
            if (tx1_ack) tx_addr_ff <= {tx_w0_ff[HI_MSB:0], rd};
            if (tx1_ack) tx_bits_ff <= tx_w0_ff[CR_BIT:DE_BIT];
            if (txw_ack) tx_idx_ff <= tx_next;
        end
    end

    //------------------------------------------------------------
    // receive side
    //------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_have_ff <= 1'b0;
            rx_idx_ff  <= RST_IDX;
            rx_eor_ff  <= 1'b0;
            rx_hi_ff   <= 8'h00;
            rx_addr_ff <= 24'h00_0000;
            rx_len_ff  <= RST_WORD;
        end else begin
            if (rx0_ack) rx_eor_ff <= rd[EOR_BIT];
            if (rx0_ack) rx_hi_ff <= rd[HI_MSB:0];
            if (rx1_ack) rx_addr_ff <= {rx_hi_ff, rd};
            if (rx2_ack) rx_len_ff <= 16'(~rd + 16'h0001);
            rx_have_ff <= rx2_ack || (rx_have_ff && !rx0w_ack);
            if (rx0w_ack) rx_idx_ff <= rx_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_pend_ff <= 1'b0;
            rx_ok_ff   <= 1'b0;
            rx_elf_ff  <= 1'b0;
            rx_mlen_ff <= RST_WORD;
            rx_bits_ff <= 4'h0;
        end else begin
            rx_pend_ff <= rx_frame_end || (rx_pend_ff && !rx0w_ack && !rx_drop);
            if (rx_frame_end) begin
                rx_ok_ff   <= rx_frame_ok;
                rx_elf_ff  <= rx_frame_elf;
                rx_mlen_ff <= rx_frame_len;
                rx_bits_ff <= rx_frame_bits;
            end
        end
    end

    //------------------------------------------------------------
    // registers and interrupt
    //------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_ff    <= 1'b0;
            tx_base_ff   <= RST_BASE;
            rx_base_ff   <= RST_BASE;
            status_ff    <= RST_STAT;
            mask_ff      <= RST_STAT;
            reg_rdata_ff <= 16'h0000;
            irq_ff       <= 1'b0;
        end else begin
            if (wr_ctrl) enable_ff <= reg_wdata[0];
            if (wr_txb) tx_base_ff <= reg_wdata[ADDR_W-1:0];
            if (wr_rxb) rx_base_ff <= reg_wdata[ADDR_W-1:0];
            if (wr_mask) mask_ff <= reg_wdata[ST_W-1:0];
            status_ff    <= (status_ff & ~(wr_stat ? reg_wdata[ST_W-1:0] : RST_STAT)) | events;
            reg_rdata_ff <= reg_rd ? rd_mux : 16'h0000;
            irq_ff       <= |(status_ff & mask_ff);
        end
    end

    assign dma.req     = req_ff;
    assign dma.we      = we_ff;
    assign dma.addr    = addr_ff;
    assign dma.wdata   = wdata_ff;
    assign reg_rdata   = reg_rdata_ff;
    assign irq         = irq_ff;
    assign tx_start    = tx_start_ff;
    assign tx_buf_addr = tx_addr_ff;
    assign tx_cr       = tx_bits_ff[4];
    assign tx_last     = tx_bits_ff[3];
    assign tx_fecn     = tx_bits_ff[2];
    assign tx_becn     = tx_bits_ff[1];
    assign tx_de       = tx_bits_ff[0];
    assign rx_ready    = rx_have_ff;
    assign rx_buf_addr = rx_addr_ff;
    assign rx_buf_len  = rx_len_ff;
endmodule : bdrf_dev_end

// *** bench/bdrf_asserts.sv ***
`timescale 1ns/1ps
//----------------
// link checks
//----------------
module bdrf_asserts import bdrf_pkg::*; (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              req,
    input wire logic              we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              ack,
    input wire logic [DATA_W-1:0] rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_w3_done;
        ack && we && addr[1:0] == 2'd3;
    endsequence
    sequence s_w0_write;
        req && we && addr[1:0] == 2'd0;
    endsequence
    a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we))
        else $error("request not held");
    a_wdata_held: assert property (req && we && !ack |=> $stable(wdata))
        else $error("write data not held");
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack too long");
    a_ack_with_req: assert property (ack |-> req)
        else $error("ack without request");
    a_rdata_idle: assert property (!ack |-> rdata == '0)
        else $error("stray read data");
    a_ack_bound: assert property ($rose(req) |-> ##[1:12] ack)
        else $error("ack too late");
    a_owner_back: assert property (s_w0_write |-> !wdata[OWN_BIT])
        else $error("owner flag kept");
    a_fixed_words: assert property (req && we |-> addr[1:0] != 2'd1 && addr[1:0] != 2'd2)
        else $error("fixed word written");
    a_len_then_own: assert property (s_w3_done |-> ##[1:4] s_w0_write)
        else $error("owner write missing");
endmodule : bdrf_asserts

// *** bench/buffer_descriptor_ring_fields_tb.sv ***
`timescale 1ns/1ps
module buffer_descriptor_ring_fields_tb import bdrf_pkg::*;;
    logic        clk_sys, rst, reg_wr, reg_rd, post_tx, post_rx, tx_done, tx_congested_flag;
    logic        rx_frame_end, rx_frame_ok, mem_rd, irq, tx_start, tx_cr, tx_fecn, tx_becn, long_frame_end_flag;
    logic        tx_de, tx_last, rx_ready, post_busy, post_refused, post_short_len;
    logic [3:0]  reg_addr, rb;
    logic [6:0]  pf;
    logic [5:0]  post_idx;
    logic [7:0]  mem_addr;
    logic [15:0] reg_wdata, reg_rdata, mem_rdata, rx_buf_len, post_len, rx_frame_len, d;
    logic [23:0] post_addr, tx_buf_addr, rx_buf_addr, ta, ra;
    int          num_errors, comparisons, n_start, n_ref, n_short, n_rdy;
    bdrf_if bus();
    bdrf_dev_end bdrf_dev_end_i (.clk_sys, .rst, .dma(bus), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .tx_start, .tx_buf_addr, .tx_cr, .tx_fecn, .tx_becn, .tx_de,
        .tx_last, .tx_done, .tx_congested_flag, .rx_frame_end, .rx_frame_ok, .rx_frame_elf(long_frame_end_flag),
        .rx_frame_len, .rx_frame_bits(rb), .rx_ready, .rx_buf_addr, .rx_buf_len);
    bdrf_host_end bdrf_host_end_i (.clk_sys, .rst, .dma(bus), .tx_ring_base(8'h00),
        .rx_ring_base(8'h40), .post_tx, .post_rx, .post_idx, .post_addr, .post_len,
        .post_eor(pf[6]), .post_more(pf[5]), .post_cr(pf[4]), .post_fecn(pf[3]),
        .post_becn(pf[2]), .post_de(pf[1]), .post_tx_irq_suppress(pf[0]), .post_busy, .post_refused,
        .post_short_len, .mem_rd, .mem_addr, .mem_rdata);
    bdrf_asserts bdrf_asserts_i (.clk_sys, .rst, .req(bus.req), .we(bus.we), .addr(bus.addr),
        .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata));
    //----------------
    // tasks
    //----------------
    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        n_start <= n_start + tx_start;
        n_ref <= n_ref + post_refused;
        n_short <= n_short + post_short_len;
        n_rdy <= n_rdy + rx_ready;
    end
    function automatic logic [15:0] w0(input logic [6:0] f, input logic [7:0] hi);
        return {1'b0, f[6], f[4], !f[5], f[3:1], f[0], hi};
    endfunction : w0
    task automatic stop_test();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_n(ref int c, input int n);
        for (int i = 0; i < 400 && c < n; i++) @(posedge clk_sys);
        if (c < n) begin
            num_errors++;
            stop_test();
        end
    endtask : wait_n
    task automatic rd(input bit m, input logic [7:0] a, output logic [15:0] q);
        @(posedge clk_sys);
        reg_addr <= a[3:0];
        mem_addr <= a;
        reg_rd <= !m;
        mem_rd <= m;
        @(posedge clk_sys);
        reg_rd <= 0;
        mem_rd <= 0;
        #1 q = m ? mem_rdata : reg_rdata;
    endtask : rd
    task automatic reg_w(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask : reg_w
    task automatic poll(input int b);
        for (int i = 0; i < 60 && d[b] !== 1'b1; i++) rd(0, REG_STATUS, d);
        chk(d[b], 1);
    endtask : poll
    task automatic post(input bit t, input logic [5:0] i, input logic [23:0] a,
                        input logic [15:0] n, input logic [6:0] f);
        @(posedge clk_sys);
        post_tx <= t;
        post_rx <= !t;
        post_idx <= i;
        post_addr <= a;
        post_len <= n;
        pf <= f;
        @(posedge clk_sys);
        post_tx <= 0;
        post_rx <= 0;
        repeat (8) @(posedge clk_sys);
    endtask : post
    task automatic rx_pulse(input logic ok, input logic [15:0] n);
        @(posedge clk_sys);
        rx_frame_end <= 1;
        rx_frame_ok <= ok;
        rx_frame_len <= n;
        {long_frame_end_flag, rb} <= 5'($urandom);
        @(posedge clk_sys);
        rx_frame_end <= 0;
    endtask : rx_pulse
    initial begin
        {reg_wr, reg_rd, post_tx, post_rx, tx_done, tx_congested_flag, rx_frame_end, rx_frame_ok,
         mem_rd, reg_addr, pf, post_idx, mem_addr, reg_wdata, post_len, rx_frame_len,
         post_addr, d} = '0;
        rst = 1;
        rb = 4'($urandom(47307));
        ta = 24'($urandom) & 24'hff_fffe;
        ra = 24'($urandom) & 24'hff_fffe;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        post(1, 6'h00, ta, 16'h0040, {2'b00, rb, 1'b1});
        post(1, 6'h00, ta, 16'h0040, 7'h00);
        post(1, 6'h01, ~ta, 16'h0010, 7'h43);
        post(0, 6'h00, ra, 16'h000e, 7'h40);
        chk(n_ref, 1);
        chk(n_short, 1);
        reg_w(REG_RX_BASE, 16'h0040);
        reg_w(REG_MASK, 16'h0007);
        reg_w(REG_CTRL, 16'h0001);
        wait_n(n_start, 1);
        chk(tx_buf_addr, ta);
        chk({tx_cr, tx_fecn, tx_becn, tx_de, tx_last}, {rb, 1'b1});
        @(posedge clk_sys);
        tx_congested_flag <= 1;
        tx_done <= 1;
        @(posedge clk_sys);
        tx_done <= 0;
        poll(ST_DISC);
        chk(d[2:0], 3'h4);
        chk(n_start, 1);
        rd(1, 8'h00, d);
        chk(d, w0({2'b00, rb, 1'b1}, ta[23:16]));
        rd(1, 8'h04, d);
        chk(d, w0(7'h43, ~ta[23:16]));
        rd(0, REG_INDEX, d);
        chk(d[5:0], 6'h00);
        $display("test tx done");
        wait_n(n_rdy, 1);
        chk(rx_buf_addr, ra);
        chk(rx_buf_len, 16'h000e);
        rx_pulse(0, 16'h0022);
        rx_pulse(1, 16'($urandom_range(1, 14)));
        poll(ST_RX);
        chk(d[2:0], 3'h6);
        chk(irq, 1);
        rd(1, 8'h43, d);
        chk(d, 16'(long_frame_end_flag ? -rx_frame_len : 16'h0000));
        rd(1, 8'h40, d);
        chk(d, w0({1'b1, !long_frame_end_flag, rb, 1'b0}, ra[23:16]));
        rd(1, 8'h41, d);
        chk(d, ra[15:0]);
        $display("test rx done");
        reg_w(REG_MASK, 16'h0000);
        rd(0, 8'h0f, d);
        chk(d, 0);
        chk(irq, 0);
        reg_w(REG_MASK, 16'h0007);
        reg_w(REG_STATUS, 16'h0007);
        rd(0, REG_STATUS, d);
        chk(d, 0);
        chk(irq, 0);
        $display("test irq done");
        stop_test();
    end
endmodule : buffer_descriptor_ring_fields_tb
